// ### src/chc_top.sv
/*
 * chc_top: one channel of input conditioning. Raw conversion results are
 * converted (unit or scaling), shifted and filtered into a process value.
 * Assumes an APB master on clk_sys and a front end on the same clock that
 * delivers raw_value with a one-cycle raw_valid strobe.
 */
// The implementer's own choices: the APB register port and the address map.
// Notes on behaviour
// R1 - unit 0 reports Celsius, 1 Fahrenheit, default 0; temperature types only
// R2 - thermocouple/infrared: method 0 external, 1 internal compensation, default internal
// R3 - unit, compensation, scaling limits and decimal point change only while stopped
// R4 - analog: range bottom maps to lower limit, top to upper, linear between
// R5 - scaling limits and decimal point ignored for temperature input types
// R6 - decimal point gives fractional digits 0 to 3, default 1
// R7 - if lower limit exceeds upper, the larger acts as upper limit
// R8 - two reference inputs and two shifts held, with given ranges and defaults
// R9 - shifts follow sensor decimal position; zero digits treated as one
// R10 - equal shifts add one offset everywhere, references ignored
// R11 - differing shifts interpolate linearly between the two reference inputs
// R12 - first-order filter, time constant 0.0 to 999.9 s, default 0.0
// R13 - shift line extrapolates beyond references; zero constant passes through
`timescale 1ns/1ps
module chc_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sensor front end
  input wire logic raw_valid,
  input wire logic signed [15:0] raw_value,
  output logic [4:0] fe_in_type,
  output logic fe_cjc_internal,
  // process value
  output logic signed [15:0] pv,
  output logic pv_valid,
  output logic [1:0] pv_dp
);
  import chc_pkg::*;

  // ***********************************************************
  // helpers
  // ***********************************************************
  function automatic logic signed [15:0] clamp_val(input logic signed [31:0] v);
    logic signed [31:0] r;
    r = v;
    if (v < CHC_VAL_MIN)
    begin
      r = CHC_VAL_MIN;
    end
    else if (v > CHC_VAL_MAX)
    begin
      r = CHC_VAL_MAX;
    end
    clamp_val = r[15:0];
  endfunction

  function automatic logic is_analog(input logic [4:0] t);
    is_analog = (t >= CHC_TYPE_AN_FIRST) && (t <= CHC_TYPE_AN_LAST);
  endfunction

  function automatic logic is_tc_ir(input logic [4:0] t);
    is_tc_ir = ((t >= CHC_TYPE_TC_FIRST) && (t <= CHC_TYPE_IR_LAST)) || (t == CHC_TYPE_MAX);
  endfunction

  // decimal digits of a temperature type
  function automatic logic [1:0] temp_dp(input logic [4:0] t);
    case (t)
      5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0a, 5'h0e, 5'h1e: temp_dp = 2'h1;
      default: temp_dp = 2'h0;
    endcase
  endfunction

  // ***********************************************************
  // register file
  // ***********************************************************
  chc_cfg_t cfg;
  logic run;
  chc_state_t state;
  logic signed [31:0] filt_y;
  logic setup;
  logic wr_en;
  logic locked_reg;
  logic mapped;
  logic signed [31:0] wval;

  assign setup = psel && !penable;
  assign wval = {{16{pwdata[15]}}, pwdata[15:0]};
  assign locked_reg = (paddr == CHC_OFS_TYPE) || (paddr == CHC_OFS_UNIT) ||
                      (paddr == CHC_OFS_CJC) || (paddr == CHC_OFS_SCL_HI) ||
                      (paddr == CHC_OFS_SCL_LO) || (paddr == CHC_OFS_DP);
  assign mapped = (paddr <= CHC_OFS_STATUS) && (paddr[1:0] == 2'b00);
  assign wr_en = psel && penable && pwrite && pready && !pslverr;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      // refuse locked writes while running and any unmapped access
      pslverr <= setup && (!mapped || (pwrite && run && locked_reg)); // [R3]
      prdata <= 32'h0000_0000;
      if (setup && !pwrite)
      begin
        case (paddr)
          CHC_OFS_CTRL: prdata <= {31'h0, run};
          CHC_OFS_TYPE: prdata <= {27'h0, cfg.in_type};
          CHC_OFS_UNIT: prdata <= {31'h0, cfg.unit_f};
          CHC_OFS_CJC: prdata <= {31'h0, cfg.cjc_int};
          CHC_OFS_SCL_HI: prdata <= {{16{cfg.scl_hi[15]}}, cfg.scl_hi};
          CHC_OFS_SCL_LO: prdata <= {{16{cfg.scl_lo[15]}}, cfg.scl_lo};
          CHC_OFS_DP: prdata <= {30'h0, cfg.dp};
          CHC_OFS_REF1: prdata <= {{16{cfg.ref1[15]}}, cfg.ref1};
          CHC_OFS_SHIFT1: prdata <= {{16{cfg.shift1[15]}}, cfg.shift1};
          CHC_OFS_REF2: prdata <= {{16{cfg.ref2[15]}}, cfg.ref2};
          CHC_OFS_SHIFT2: prdata <= {{16{cfg.shift2[15]}}, cfg.shift2};
          CHC_OFS_TAU: prdata <= {18'h0, cfg.tau};
          CHC_OFS_PV: prdata <= {{16{pv[15]}}, pv};
          CHC_OFS_STATUS: prdata <= {30'h0, run, state != CHC_ST_IDLE};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      run <= 1'b0;
      cfg.in_type <= CHC_RST_TYPE;
      cfg.unit_f <= CHC_RST_UNIT; // [R1]
      cfg.cjc_int <= CHC_RST_CJC; // [R2]
      cfg.scl_hi <= CHC_RST_SCL_HI; // [R4]
      cfg.scl_lo <= CHC_RST_SCL_LO;
      cfg.dp <= CHC_RST_DP; // [R6]
      cfg.ref1 <= CHC_RST_REF1; // [R8]
      cfg.shift1 <= CHC_RST_SHIFT;
      cfg.ref2 <= CHC_RST_REF2;
      cfg.shift2 <= CHC_RST_SHIFT;
      cfg.tau <= CHC_RST_TAU; // [R12]
    end
    else if (wr_en)
    begin
      case (paddr)
        CHC_OFS_CTRL: run <= pwdata[CHC_CTRL_RUN_BIT];
        CHC_OFS_TYPE: cfg.in_type <= (pwdata[4:0] > CHC_TYPE_MAX) ? CHC_TYPE_MAX : pwdata[4:0];
        CHC_OFS_UNIT: cfg.unit_f <= pwdata[0]; // [R3]
        CHC_OFS_CJC: cfg.cjc_int <= pwdata[0]; // [R3]
        CHC_OFS_SCL_HI: cfg.scl_hi <= clamp_val(wval); // [R4]
        CHC_OFS_SCL_LO: cfg.scl_lo <= clamp_val(wval); // [R4]
        CHC_OFS_DP: cfg.dp <= pwdata[1:0]; // [R6]
        CHC_OFS_REF1: cfg.ref1 <= clamp_val(wval); // [R8]
        CHC_OFS_SHIFT1: cfg.shift1 <= clamp_val(wval); // [R8]
        CHC_OFS_REF2: cfg.ref2 <= clamp_val(wval); // [R8]
        CHC_OFS_SHIFT2: cfg.shift2 <= clamp_val(wval); // [R8]
        CHC_OFS_TAU: cfg.tau <= (pwdata[13:0] > 14'd9999) ? 14'd9999 : pwdata[13:0]; // [R12]
        default: run <= run;
      endcase
    end
  end

  // ***********************************************************
  // shared sequential divider (signed, truncating)
  // ***********************************************************
  logic div_start;
  logic div_done;
  logic signed [39:0] div_num;
  logic signed [23:0] div_den;
  logic [39:0] dq;
  logic [23:0] drem;
  logic [23:0] dd;
  logic dneg;
  logic [5:0] dcnt;
  logic [24:0] dtrial;
  logic signed [39:0] div_q;

  assign dtrial = {drem, dq[39]};
  assign div_q = dneg ? -$signed(dq) : $signed(dq);

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dq <= 40'h0;
      drem <= 24'h0;
      dd <= 24'h0;
      dneg <= 1'b0;
      dcnt <= 6'h0;
      div_done <= 1'b0;
    end
    else
    begin
      div_done <= 1'b0;
      if (div_start)
      begin
        dq <= div_num[39] ? 40'(-div_num) : 40'(div_num);
        dd <= div_den[23] ? 24'(-div_den) : 24'(div_den);
        dneg <= div_num[39] ^ div_den[23];
        drem <= 24'h0;
        dcnt <= 6'(CHC_DIV_STEPS);
      end
      else if (dcnt != 6'h0)
      begin
        if (dtrial >= {1'b0, dd})
        begin
          drem <= 24'(dtrial - {1'b0, dd});
          dq <= {dq[38:0], 1'b1};
        end
        else
        begin
          drem <= dtrial[23:0];
          dq <= {dq[38:0], 1'b0};
        end
        dcnt <= dcnt - 6'h1;
        div_done <= (dcnt == 6'h1);
      end
    end
  end

  // ***********************************************************
  // conditioning pipeline
  // ***********************************************************
  logic [1:0] eff_dp;
  logic signed [15:0] lo_eff;
  logic signed [15:0] hi_eff;
  logic signed [31:0] conv_val;
  logic signed [31:0] corr_val;
  logic signed [31:0] next_corr;
  logic signed [16:0] ref_span;
  logic signed [16:0] shift_span;
  logic signed [4:0] shift_k;
  logic primed;

  // temperature types use their own decimal digits, analog the programmed ones
  assign eff_dp = is_analog(cfg.in_type) ? cfg.dp : temp_dp(cfg.in_type); // [R5] [R6]
  assign lo_eff = (cfg.scl_lo > cfg.scl_hi) ? cfg.scl_hi : cfg.scl_lo; // [R7]
  assign hi_eff = (cfg.scl_lo > cfg.scl_hi) ? cfg.scl_lo : cfg.scl_hi; // [R7]
  assign ref_span = 17'(cfg.ref2) - 17'(cfg.ref1);
  assign shift_span = 17'(cfg.shift2) - 17'(cfg.shift1);
  // shifts carry one digit more than the value when it has none
  assign shift_k = (eff_dp == 2'h0) ? 5'sd10 : 5'sd1; // [R9]
  assign next_corr = corr_val + 32'(div_q);

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= CHC_ST_IDLE;
      div_start <= 1'b0;
      div_num <= 40'sh0;
      div_den <= 24'sh1;
      conv_val <= 32'sh0;
      corr_val <= 32'sh0;
      filt_y <= 32'sh0;
      primed <= 1'b0;
    end
    else
    begin
      div_start <= 1'b0;
      case (state)
        CHC_ST_IDLE:
        begin
          if (raw_valid)
          begin
            div_start <= 1'b1;
            state <= CHC_ST_CONV;
            if (is_analog(cfg.in_type))
            begin
              // raw is the 12-bit position within the input range
              div_num <= 40'(32'(hi_eff - lo_eff) * $signed({1'b0, raw_value[11:0]})); // [R4]
              div_den <= CHC_ADC_FULL;
              conv_val <= 32'(lo_eff); // [R4]
            end
            else if (cfg.unit_f)
            begin
              div_num <= 40'(32'(raw_value) * 32'sd9); // [R1]
              div_den <= 24'sd5;
              conv_val <= (temp_dp(cfg.in_type) == 2'h1) ? 32'sd320 : 32'sd32; // [R1]
            end
            else
            begin
              div_num <= 40'(raw_value); // [R1]
              div_den <= 24'sd1;
              conv_val <= 32'sh0;
            end
          end
        end
        CHC_ST_CONV:
        begin
          if (div_done)
          begin
            corr_val <= conv_val + 32'(div_q);
            div_start <= 1'b1;
            state <= CHC_ST_SHIFT;
            if ((cfg.shift1 == cfg.shift2) || (ref_span == 17'sh0))
            begin
              div_num <= 40'(cfg.shift1); // [R10]
              div_den <= 24'(shift_k);
            end
            else
            begin
              // line through both points, extended past them
              div_num <= 40'(40'(cfg.shift1) * 40'(ref_span) + 40'(shift_span) *
                         40'(conv_val + 32'(div_q) - 32'(cfg.ref1))); // [R11] [R13]
              div_den <= 24'(24'(ref_span) * 24'(shift_k)); // [R9] [R11]
            end
          end
        end
        CHC_ST_SHIFT:
        begin
          if (div_done)
          begin
            corr_val <= next_corr;
            if ((cfg.tau == 14'h0) || !primed)
            begin
              filt_y <= next_corr <<< CHC_FRAC; // [R13]
              primed <= 1'b1;
              state <= CHC_ST_OUT;
            end
            else
            begin
              div_num <= 40'((next_corr <<< CHC_FRAC) - filt_y); // [R12]
              div_den <= 24'({10'h0, cfg.tau} + {10'h0, CHC_SAMPLE_DS}); // [R12]
              div_start <= 1'b1;
              state <= CHC_ST_FILT;
            end
          end
        end
        CHC_ST_FILT:
        begin
          if (div_done)
          begin
            filt_y <= filt_y + 32'(div_q); // [R12]
            state <= CHC_ST_OUT;
          end
        end
        CHC_ST_OUT:
        begin
          state <= CHC_ST_IDLE;
        end
        default:
        begin
          state <= CHC_ST_IDLE;
        end
      endcase
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pv <= 16'sh0;
      pv_valid <= 1'b0;
      pv_dp <= CHC_RST_DP;
      fe_in_type <= CHC_RST_TYPE;
      fe_cjc_internal <= CHC_RST_CJC;
    end
    else
    begin
      pv_valid <= (state == CHC_ST_OUT);
      if (state == CHC_ST_OUT)
      begin
        pv <= 16'(filt_y >>> CHC_FRAC);
        pv_dp <= eff_dp;
      end
      fe_in_type <= cfg.in_type;
      // compensation choice only matters for thermocouple and infrared inputs
      fe_cjc_internal <= is_tc_ir(cfg.in_type) ? cfg.cjc_int : 1'b0; // [R2]
    end
  end

endmodule

// ### src/chc_pkg.sv
/*
 * chc_pkg: constants, register map and configuration carrier for the
 * channel input conditioning block.
 * Assumes a 32-bit APB master and a 50 MHz system clock.
 */
package chc_pkg;

  // ***********************************************************
  // register offsets (byte addresses)
  // ***********************************************************
  localparam logic [7:0] CHC_OFS_CTRL = 8'h00;
  localparam logic [7:0] CHC_OFS_TYPE = 8'h04;
  localparam logic [7:0] CHC_OFS_UNIT = 8'h08;
  localparam logic [7:0] CHC_OFS_CJC = 8'h0c;
  localparam logic [7:0] CHC_OFS_SCL_HI = 8'h10;
  localparam logic [7:0] CHC_OFS_SCL_LO = 8'h14;
  localparam logic [7:0] CHC_OFS_DP = 8'h18;
  localparam logic [7:0] CHC_OFS_REF1 = 8'h1c;
  localparam logic [7:0] CHC_OFS_SHIFT1 = 8'h20;
  localparam logic [7:0] CHC_OFS_REF2 = 8'h24;
  localparam logic [7:0] CHC_OFS_SHIFT2 = 8'h28;
  localparam logic [7:0] CHC_OFS_TAU = 8'h2c;
  localparam logic [7:0] CHC_OFS_PV = 8'h30;
  localparam logic [7:0] CHC_OFS_STATUS = 8'h34;

  // ***********************************************************
  // field positions
  // ***********************************************************
  localparam int CHC_CTRL_RUN_BIT = 0;
  localparam int CHC_STAT_BUSY_BIT = 0;
  localparam int CHC_STAT_RUN_BIT = 1;

  // ***********************************************************
  // reset values and ranges (counts of the last shown digit)
  // ***********************************************************
  localparam logic [4:0] CHC_RST_TYPE = 5'h05;
  localparam logic CHC_RST_UNIT = 1'b0;
  localparam logic CHC_RST_CJC = 1'b1;
  localparam logic signed [15:0] CHC_RST_SCL_HI = 16'sh03e8;
  localparam logic signed [15:0] CHC_RST_SCL_LO = 16'sh0000;
  localparam logic [1:0] CHC_RST_DP = 2'h1;
  localparam logic signed [15:0] CHC_RST_REF1 = 16'sh0000;
  localparam logic signed [15:0] CHC_RST_REF2 = 16'sh03e8;
  localparam logic signed [15:0] CHC_RST_SHIFT = 16'sh0000;
  localparam logic [13:0] CHC_RST_TAU = 14'h0000;
  localparam logic signed [31:0] CHC_VAL_MIN = -32'sd1999;
  localparam logic signed [31:0] CHC_VAL_MAX = 32'sd9999;
  localparam logic [4:0] CHC_TYPE_MAX = 5'h1e;
  localparam logic [4:0] CHC_TYPE_TC_FIRST = 5'h05;
  localparam logic [4:0] CHC_TYPE_IR_LAST = 5'h18;
  localparam logic [4:0] CHC_TYPE_AN_FIRST = 5'h19;
  localparam logic [4:0] CHC_TYPE_AN_LAST = 5'h1d;

  // ***********************************************************
  // arithmetic and timing
  // ***********************************************************
  localparam logic signed [23:0] CHC_ADC_FULL = 24'sd4095;
  localparam int CHC_FRAC = 8;
  localparam int CHC_DIV_STEPS = 40;
  // interval between raw samples in tenths of a second
  localparam logic [13:0] CHC_SAMPLE_DS = 14'h0001;

  // ***********************************************************
  // configuration carrier
  // ***********************************************************
  typedef struct packed {
    logic [4:0] in_type;
    logic unit_f;
    logic cjc_int;
    logic signed [15:0] scl_hi;
    logic signed [15:0] scl_lo;
    logic [1:0] dp;
    logic signed [15:0] ref1;
    logic signed [15:0] shift1;
    logic signed [15:0] ref2;
    logic signed [15:0] shift2;
    logic [13:0] tau;
  } chc_cfg_t;

  typedef enum logic [2:0] {
    CHC_ST_IDLE = 3'b000,
    CHC_ST_CONV = 3'b001,
    CHC_ST_SHIFT = 3'b011,
    CHC_ST_FILT = 3'b010,
    CHC_ST_OUT = 3'b110
  } chc_state_t;

endpackage

// ### bench/chc_fe_model.sv
/*
 * chc_fe_model: sensor front end seen by one conditioning channel.
 * Assumes the bench raises go for one cycle to launch a conversion result.
 */
`timescale 1ns/1ps
module chc_fe_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // bench request
  input wire logic go,
  input wire logic signed [15:0] fe_val,
  // conversion result
  output logic raw_valid,
  output logic signed [15:0] raw_value
);
  import chc_pkg::*;
  // ***********************************************************
  // one-cycle result strobe; the data line toggles outside it
  // ***********************************************************
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      raw_valid <= 1'b0;
      raw_value <= 16'sh0000;
    end
    else if (go)
    begin
      raw_valid <= 1'b1;
      raw_value <= fe_val;
    end
    else
    begin
      raw_valid <= 1'b0;
      raw_value <= ~raw_value;
    end
endmodule

// ### bench/chc_assertions.sv
/*
 * chc_checker: port-level properties of one conditioning channel.
 * Assumes the APB master holds psel through the access phase.
 */
`timescale 1ns/1ps
module chc_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // sensor side
  input wire logic raw_valid,
  input wire logic [4:0] fe_in_type,
  input wire logic fe_cjc_internal,
  input wire logic signed [15:0] pv,
  input wire logic pv_valid
);
  import chc_pkg::*;
  logic busy_q;
  logic run_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // ***********************************************************
  // shadow of pipeline occupancy and run state
  // ***********************************************************
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      busy_q <= 1'b0;
    else if (raw_valid)
      busy_q <= 1'b1;
    else if (pv_valid)
      busy_q <= 1'b0;
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      run_q <= 1'b0;
    else if (pready && pwrite && !pslverr && paddr == CHC_OFS_CTRL)
      run_q <= pwdata[0];
  a_access_answer: assert property (psel && !penable |=> pready && penable)
    else $error("no answer in access cycle");
  a_prdata_idle: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data or error outside access");
  a_lock_refuse: assert property (psel && penable && pwrite && run_q &&
    paddr >= CHC_OFS_TYPE && paddr <= CHC_OFS_DP && paddr[1:0] == 2'h0 |-> pslverr)
    else $error("locked write not refused");
  a_type_frozen: assert property (run_q && $past(run_q, 2) |-> $stable(fe_in_type))
    else $error("input type changed while running");
  a_cjc_gate: assert property ($stable(fe_in_type) &&
    (fe_in_type < 5'h05 || (fe_in_type > 5'h18 && fe_in_type != 5'h1e)) |-> !fe_cjc_internal)
    else $error("compensation flagged for non-thermocouple type");
  a_take_answer: assert property (raw_valid && (!busy_q || pv_valid) |-> ##[82:130] pv_valid)
    else $error("process value late");
  a_pv_unprompted: assert property (pv_valid |-> busy_q)
    else $error("process value without sample");
  a_pv_pulse: assert property (pv_valid |=> !pv_valid)
    else $error("valid strobe too long");
  a_pv_holds: assert property (!pv_valid |-> $stable(pv))
    else $error("process value moved without strobe");
  c_pv: cover property (pv_valid);
  c_err: cover property (pslverr);
  c_run_write: cover property (run_q && pready && pwrite);
endmodule
bind chc_top chc_checker u_chk (
  .clk_sys(clk_sys),
  .arst_n(arst_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .raw_valid(raw_valid),
  .fe_in_type(fe_in_type),
  .fe_cjc_internal(fe_cjc_internal),
  .pv(pv),
  .pv_valid(pv_valid)
);

// ### bench/test_channel_input_conditioning.sv
/*
 * test_channel_input_conditioning: directed bench for one channel.
 * Assumes chc_top, chc_fe_model and the bound checker are compiled first.
 */
`timescale 1ns/1ps
module test_channel_input_conditioning;
  import chc_pkg::*;
  logic clk_sys, arst_n, psel, penable, pwrite, go, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, raw_valid, pv_valid, fe_cjc_internal;
  logic signed [15:0] raw_value, fe_val, pv;
  logic [4:0] fe_in_type;
  logic [1:0] pv_dp;
  int failures, total_checks;
  logic [7:0] ra [11] = '{CHC_OFS_TYPE, CHC_OFS_UNIT, CHC_OFS_CJC, CHC_OFS_SCL_HI,
    CHC_OFS_SCL_LO, CHC_OFS_DP, CHC_OFS_REF1, CHC_OFS_SHIFT1, CHC_OFS_REF2,
    CHC_OFS_SHIFT2, CHC_OFS_TAU};
  logic [31:0] rv [11] = '{32'h5, 32'h0, 32'h1, 32'h3e8, 32'h0, 32'h1, 32'h0, 32'h0,
    32'h3e8, 32'h0, 32'h0};
  chc_top dut (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .raw_valid(raw_valid), .raw_value(raw_value),
    .fe_in_type(fe_in_type), .fe_cjc_internal(fe_cjc_internal), .pv(pv),
    .pv_valid(pv_valid), .pv_dp(pv_dp));
  chc_fe_model fe (.clk_sys(clk_sys), .arst_n(arst_n), .go(go), .fe_val(fe_val),
    .raw_valid(raw_valid), .raw_value(raw_value));
  // ***********************************************************
  // clock, checking and bus tasks
  // ***********************************************************
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task tally_and_finish;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      check("apb timeout", 32'h1, 32'h0);
      tally_and_finish;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask
  task sample(input logic signed [15:0] v, input logic signed [15:0] ev, input logic [1:0] dp);
    int n;
    @(posedge clk_sys);
    go <= 1'b1;
    fe_val <= v;
    @(posedge clk_sys);
    go <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (pv_valid !== 1'b1 && n < 300);
    if (n >= 300)
    begin
      check("pv timeout", 32'h1, 32'h0);
      tally_and_finish;
    end
    check("pv", pv, ev);
    check("pv_dp", pv_dp, dp);
  endtask
  // ***********************************************************
  // test sequence
  // ***********************************************************
  initial
  begin
    {psel, penable, pwrite, go, arst_n} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fe_val = 16'sh0000;
    failures = 0;
    total_checks = 0;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int i = 0; i < 11; i++)
    begin
      apb(1'b0, ra[i], 32'h0, q, e);
      check("reset value", q, rv[i]);
    end
    apb(1'b0, 8'h38, 32'h0, q, e);
    check("unmapped error", e, 32'h1);
    $display("test registers done");
    wr(CHC_OFS_SHIFT1, 32'd20);
    wr(CHC_OFS_SHIFT2, 32'd20);
    sample(16'sd200, 16'sd202, 2'h0);
    wr(CHC_OFS_UNIT, 32'h1);
    sample(16'sd100, 16'sd214, 2'h0);
    wr(CHC_OFS_UNIT, 32'h0);
    $display("test one-point shift and unit done");
    wr(CHC_OFS_CTRL, 32'h1);
    apb(1'b0, CHC_OFS_STATUS, 32'h0, q, e);
    check("status run", q, 32'h2);
    apb(1'b1, CHC_OFS_UNIT, 32'h1, q, e);
    check("locked write error", e, 32'h1);
    apb(1'b0, CHC_OFS_UNIT, 32'h0, q, e);
    check("locked unit", q, 32'h0);
    wr(CHC_OFS_CTRL, 32'h0);
    $display("test run lock done");
    wr(CHC_OFS_SHIFT1, 32'd0);
    wr(CHC_OFS_SHIFT2, 32'd100);
    sample(16'sd500, 16'sd505, 2'h0);
    sample(16'sd1500, 16'sd1515, 2'h0);
    wr(CHC_OFS_CJC, 32'h0);
    repeat (3) @(posedge clk_sys);
    check("cjc internal", fe_cjc_internal, 32'h0);
    wr(CHC_OFS_CJC, 32'h1);
    $display("test two-point shift done");
    wr(CHC_OFS_SHIFT2, 32'd0);
    wr(CHC_OFS_TYPE, 32'd25);
    wr(CHC_OFS_SCL_HI, 32'd100);
    wr(CHC_OFS_SCL_LO, 32'd900);
    wr(CHC_OFS_DP, 32'h2);
    sample(16'sd4095, 16'sd900, 2'h2);
    sample(16'sd0, 16'sd100, 2'h2);
    check("front end type", fe_in_type, 32'd25);
    check("cjc gated", fe_cjc_internal, 32'h0);
    wr(CHC_OFS_TYPE, 32'd6);
    wr(CHC_OFS_UNIT, 32'h1);
    wr(CHC_OFS_SHIFT1, 32'd15);
    wr(CHC_OFS_SHIFT2, 32'd15);
    sample(16'sd1000, 16'sd2135, 2'h1);
    check("cjc type 6", fe_cjc_internal, 32'h1);
    wr(CHC_OFS_UNIT, 32'h0);
    wr(CHC_OFS_SHIFT1, 32'd0);
    wr(CHC_OFS_SHIFT2, 32'd0);
    wr(CHC_OFS_TYPE, 32'd5);
    sample(16'sd300, 16'sd300, 2'h0);
    $display("test scaling done");
    wr(CHC_OFS_TAU, 32'h1);
    sample(16'sd500, 16'sd400, 2'h0);
    wr(CHC_OFS_TAU, 32'h0);
    sample(16'sd50, 16'sd50, 2'h0);
    apb(1'b0, CHC_OFS_PV, 32'h0, q, e);
    check("pv register", q, 32'd50);
    $display("test filter done");
    tally_and_finish;
  end
endmodule
